//--- charger_code_decode.sv
`timescale 1ns/1ps
`default_nettype none

module charger_code_decode (
    // Codes from the register bank
    input wire logic [charger_regs_pkg::CODE_W-1:0] dead_batt_current_code,
    input wire logic recharge_threshold_sel,
    input wire logic [charger_regs_pkg::CODE_W-1:0] vbat_reg_code,
    // Physical values for the analog loop
    output logic [charger_regs_pkg::MA_W-1:0] dead_batt_ma,
    output logic [charger_regs_pkg::RECHARGE_MV_W-1:0] recharge_drop_mv,
    output logic [charger_regs_pkg::VREG_MV_W-1:0] vbat_reg_mv
);
    import charger_regs_pkg::*;

    // ------------------------------------------------------------
    // Code to value mapping
    // ------------------------------------------------------------
    // Dead battery current is one milliamp per code
    assign dead_batt_ma = dead_batt_current_code;

    // Recharge drop below the regulation voltage
    assign recharge_drop_mv = recharge_threshold_sel ? RECHARGE_HIGH_DROP_MV
                                                     : RECHARGE_LOW_DROP_MV;

    // Linear ramp, upper codes clamp so a stray code cannot overcharge
    always_comb begin
        if (vbat_reg_code >= VREG_SAT_CODE) begin
            vbat_reg_mv = VREG_MAX_MV;
        end else begin
            vbat_reg_mv = VREG_BASE_MV + VREG_STEP_MV * {7'h00, vbat_reg_code};
        end
    end

endmodule // charger_code_decode

`default_nettype wire

//--- charger_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module charger_host_model (
    // Register port toward the device
    input wire logic sys_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wr_data
);
    // Strobes idle low from time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    // Idle data is inverted so nothing stale looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // charger_host_model
`default_nettype wire

//--- charger_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module charger_regs_monitor
    import charger_regs_pkg::*;
(
    // Clock, reset and register port
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_valid,
    input wire logic reg_wr_refused,
    input wire logic charger_write_lock,
    // Settings toward the charger loop
    input wire logic [5:0] dead_batt_current_code,
    input wire logic recharge_threshold_sel,
    input wire logic [5:0] vbat_reg_code,
    input wire logic [5:0] dead_batt_ma,
    input wire logic [7:0] recharge_drop_mv,
    input wire logic [12:0] vbat_reg_mv
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_rd_answer_once: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    a_vreg_write_lands: assert property (reg_wr_en && !charger_write_lock
        && reg_addr == RECHARGE_REG_VOLT_OFFSET |=>
        {1'b0, recharge_threshold_sel, vbat_reg_code} == ($past(reg_wr_data) & 8'h7f))
        else $error("voltage write lost");
    a_dead_write_lands: assert property (reg_wr_en && !charger_write_lock
        && reg_addr == DEAD_BATT_CURRENT_OFFSET |=>
        {2'b00, dead_batt_current_code} == ($past(reg_wr_data) & 8'h3f))
        else $error("dead current write lost");
    // Locked writes to either register bounce and leave the codes alone
    a_lock_blocks: assert property (reg_wr_en && charger_write_lock
        && reg_addr[7:1] == 7'h0a |=> reg_wr_refused && $stable(vbat_reg_code)
        && $stable(dead_batt_current_code)) else $error("locked write took effect");
    // A refusal only ever follows a locked write to one of the two offsets
    a_refuse_cause: assert property (reg_wr_refused |-> $past(reg_wr_en)
        && $past(charger_write_lock) && $past(reg_addr[7:1]) == 7'h0a)
        else $error("refusal without locked write");
    a_idle_holds: assert property (!reg_wr_en |=> $stable(vbat_reg_code)
        && $stable(recharge_threshold_sel) && $stable(dead_batt_current_code))
        else $error("code changed without write");
    a_ma_tracks: assert property (dead_batt_ma == $past(dead_batt_current_code))
        else $error("mA decode wrong");
    a_drop_tracks: assert property (recharge_drop_mv == ($past(recharge_threshold_sel)
        ? RECHARGE_HIGH_DROP_MV : RECHARGE_LOW_DROP_MV)) else $error("drop wrong");
    a_vreg_tracks: assert property (vbat_reg_mv == (($past(vbat_reg_code) > VREG_SAT_CODE)
        ? VREG_MAX_MV : VREG_BASE_MV + VREG_STEP_MV * $past(vbat_reg_code)))
        else $error("regulation mV wrong");
endmodule // charger_regs_monitor
bind charger_voltage_current_regs charger_regs_monitor i_mon (.*);
`default_nettype wire

//--- charger_regs_pkg.sv
package charger_regs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DEAD_BATT_CURRENT_OFFSET = 8'h14;
    localparam logic [7:0] RECHARGE_REG_VOLT_OFFSET = 8'h15;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int CODE_W = 6;
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 5;
    localparam int RECHARGE_SEL_BIT = 6;
    localparam int RSVD_BIT = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DEAD_BATT_CURRENT_RESET = 8'h04;
    localparam logic [7:0] RECHARGE_REG_VOLT_RESET = 8'h1e;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Analog scaling of the codes
    // ------------------------------------------------------------
    localparam int MA_W = 6;
    localparam int RECHARGE_MV_W = 8;
    localparam int VREG_MV_W = 13;
    localparam logic [12:0] VREG_BASE_MV = 13'h0e10;
    localparam logic [12:0] VREG_STEP_MV = 13'h0014;
    localparam logic [12:0] VREG_MAX_MV = 13'h11f8;
    localparam logic [5:0] VREG_SAT_CODE = 6'h32;
    localparam logic [7:0] RECHARGE_LOW_DROP_MV = 8'h8c;
    localparam logic [7:0] RECHARGE_HIGH_DROP_MV = 8'hf0;
    localparam logic [5:0] DEAD_MA_RESET = 6'h04;
    localparam logic [12:0] VREG_MV_RESET = 13'h1068;

endpackage

//--- charger_voltage_current_regs.sv
`timescale 1ns/1ps
`default_nettype none

module charger_voltage_current_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port from the serial interface logic
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [charger_regs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [charger_regs_pkg::DATA_W-1:0] reg_wr_data,
    output logic [charger_regs_pkg::DATA_W-1:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic reg_wr_refused,
    // Lock state and neighbouring field
    input wire logic charger_write_lock,
    input wire logic [charger_regs_pkg::CODE_W-1:0] precharge_current_code,
    // Settings for the analog charger loop
    output logic [charger_regs_pkg::CODE_W-1:0] dead_batt_current_code,
    output logic recharge_threshold_sel,
    output logic [charger_regs_pkg::CODE_W-1:0] vbat_reg_code,
    output logic [charger_regs_pkg::MA_W-1:0] dead_batt_ma,
    output logic [charger_regs_pkg::RECHARGE_MV_W-1:0] recharge_drop_mv,
    output logic [charger_regs_pkg::VREG_MV_W-1:0] vbat_reg_mv,
    output logic dead_above_precharge
);
    import charger_regs_pkg::*;

    // ------------------------------------------------------------
    // Register map summary
    // ------------------------------------------------------------
    // Current register 14h, bits 5:0: dead battery code, reset 04h, 1 mA a step
    // Current register 14h, bits 7:6: spare, reset 0, stored and read back only
    // Voltage register 15h, bits 5:0: regulation code, reset 1Eh
    // Voltage register 15h, bit 6: recharge drop select, reset 0
    // Voltage register 15h, bit 7: spare, reset 0, stored and read back only
    // Both offsets share one write lock and one refusal flag
    // Decoded values trail the stored codes by one clock
    // Other offsets: writes ignored, reads return zero

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole register image, one flop set
    typedef struct packed {
        logic [DATA_W-1:0] dead_current;
        logic [DATA_W-1:0] recharge_volt;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic wr_refused;
        logic [MA_W-1:0] dead_ma;
        logic [RECHARGE_MV_W-1:0] drop_mv;
        logic [VREG_MV_W-1:0] vreg_mv;
        logic over_precharge;
    } state_t;

    localparam state_t STATE_RESET = '{
        dead_current: DEAD_BATT_CURRENT_RESET,
        recharge_volt: RECHARGE_REG_VOLT_RESET,
        rd_data: UNMAPPED_READ_VALUE,
        rd_valid: 1'b0,
        wr_refused: 1'b0,
        dead_ma: DEAD_MA_RESET,
        drop_mv: RECHARGE_LOW_DROP_MV,
        vreg_mv: VREG_MV_RESET,
        over_precharge: 1'b0
    };

    // Register image and its next value
    state_t state_reg;
    state_t state_next;

    // Address hits and decoded values
    logic hit_dead;
    logic hit_recharge;
    logic [MA_W-1:0] dec_dead_ma;
    logic [RECHARGE_MV_W-1:0] dec_drop_mv;
    logic [VREG_MV_W-1:0] dec_vreg_mv;

    // Write qualifiers and stored field views
    logic wr_to_bank;
    logic wr_block;
    logic wr_accept;
    logic dead_wr_accept;
    logic volt_wr_accept;
    logic [CODE_W-1:0] stored_dead_code;
    logic stored_recharge_sel;
    logic [CODE_W-1:0] stored_vreg_code;
    logic [DATA_W-1:0] rd_word;
    logic dead_gt_precharge;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign hit_dead = (reg_addr == DEAD_BATT_CURRENT_OFFSET);
    assign hit_recharge = (reg_addr == RECHARGE_REG_VOLT_OFFSET);

    // ------------------------------------------------------------
    // Write qualification
    // ------------------------------------------------------------
    // Only the two charger offsets are guarded; others fall through untouched
    assign wr_to_bank = reg_wr_en && (hit_dead || hit_recharge);
    // Lock high closes both offsets for the whole write cycle
    assign wr_block = wr_to_bank && charger_write_lock;
    assign wr_accept = wr_to_bank && !charger_write_lock;
    // One target per write, the two hits are exclusive
    assign dead_wr_accept = wr_accept && hit_dead;
    assign volt_wr_accept = wr_accept && hit_recharge;

    // ------------------------------------------------------------
    // Stored field views
    // ------------------------------------------------------------
    // Spare bits stay out of every view, so they steer nothing
    assign stored_dead_code = state_reg.dead_current[CODE_MSB:CODE_LSB];
    assign stored_recharge_sel = state_reg.recharge_volt[RECHARGE_SEL_BIT];
    assign stored_vreg_code = state_reg.recharge_volt[CODE_MSB:CODE_LSB];

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    // Unmapped offsets answer zero so a host scan sees clean gaps
    assign rd_word = hit_dead ? state_reg.dead_current
                   : hit_recharge ? state_reg.recharge_volt
                   : UNMAPPED_READ_VALUE;

    // ------------------------------------------------------------
    // Advisory compare
    // ------------------------------------------------------------
    // Host misuse is only flagged; clamping would hide the host's intent
    assign dead_gt_precharge = (stored_dead_code > precharge_current_code);

    // ------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------
    // Decoded values come from the stored codes, so they lag a write by one clock
    charger_code_decode u_decode (
        .dead_batt_current_code(stored_dead_code),
        .recharge_threshold_sel(stored_recharge_sel),
        .vbat_reg_code(stored_vreg_code),
        .dead_batt_ma(dec_dead_ma),
        .recharge_drop_mv(dec_drop_mv),
        .vbat_reg_mv(dec_vreg_mv)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // A read in the same cycle as a write returns the value before the write
    always_comb begin
        state_next = state_reg;
        // Read answer pulses one clock after the strobe
        state_next.rd_valid = reg_rd_en;
        // Refusal pulses for one clock and stores nothing
        state_next.wr_refused = wr_block;

        // Writes land only while the lock is open
        if (dead_wr_accept) begin
            state_next.dead_current = reg_wr_data;
        end
        if (volt_wr_accept) begin
            // All eight bits stored, bit 7 included but unused
            state_next.recharge_volt = reg_wr_data;
        end

        // Read data holds between reads
        if (reg_rd_en) begin
            state_next.rd_data = rd_word;
        end

        // Register the decoded settings so the analog side sees clean levels
        state_next.dead_ma = dec_dead_ma;
        state_next.drop_mv = dec_drop_mv;
        state_next.vreg_mv = dec_vreg_mv;

        // Advisory only: the device still honours whatever the host wrote
        state_next.over_precharge = dead_gt_precharge;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Register port answers
    assign reg_rd_data = state_reg.rd_data;
    assign reg_rd_valid = state_reg.rd_valid;
    assign reg_wr_refused = state_reg.wr_refused;

    // Raw codes straight from storage
    assign dead_batt_current_code = stored_dead_code;
    assign recharge_threshold_sel = stored_recharge_sel;
    assign vbat_reg_code = stored_vreg_code;

    // Registered physical values
    assign dead_batt_ma = state_reg.dead_ma;
    assign recharge_drop_mv = state_reg.drop_mv;
    assign vbat_reg_mv = state_reg.vreg_mv;

    // Advisory flag, the host keeps the final say
    assign dead_above_precharge = state_reg.over_precharge;

endmodule // charger_voltage_current_regs

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
    import charger_regs_pkg::*;
    localparam logic [7:0] EDGE_CODES [3] = '{8'h32, 8'h73, 8'hbf};
    logic sys_clk = 1'b0, rst_b = 1'b0, charger_write_lock = 1'b0;
    logic [5:0] precharge_current_code = 6'h3f;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_wr_refused, recharge_threshold_sel;
    logic dead_above_precharge;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, recharge_drop_mv, v, d, exp_rd;
    logic [5:0] dead_batt_current_code, vbat_reg_code, dead_batt_ma;
    logic [12:0] vbat_reg_mv;
    logic [7:0] exp_q[$];
    int num_errors = 0, num_checks = 0, cycles = 0;
    charger_host_model i_host (.sys_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);
    charger_voltage_current_regs i_charger_voltage_current_regs (.sys_clk, .rst_b,
        .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
        .reg_wr_refused, .charger_write_lock, .precharge_current_code, .dead_batt_current_code,
        .recharge_threshold_sel, .vbat_reg_code, .dead_batt_ma, .recharge_drop_mv,
        .vbat_reg_mv, .dead_above_precharge);
    always #12.5 sys_clk = ~sys_clk;
    // Hang guard, far above the roughly 110 cycles needed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    // Read data is compared against the oldest noted value
    always @(negedge sys_clk) if (reg_rd_valid === 1'b1) begin
        if (exp_q.size() == 0) begin
            num_errors++;
            $display("[ERR] %0t read answer with no expectation", $time);
        end else begin
            exp_rd = exp_q.pop_front();
            `CHK(reg_rd_data, exp_rd)
        end
    end
    function automatic logic [12:0] vmv(input logic [5:0] c);
        return (c > VREG_SAT_CODE) ? VREG_MAX_MV : VREG_BASE_MV + VREG_STEP_MV * c;
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        v = 8'($urandom(32'hedd8));
        repeat (10) @(negedge sys_clk);
        rst_b = 1'b1;
        `CHK(dead_batt_ma, DEAD_MA_RESET)
        `CHK(vbat_reg_mv, VREG_MV_RESET)
        `CHK(recharge_drop_mv, RECHARGE_LOW_DROP_MV)
        exp_q.push_back(DEAD_BATT_CURRENT_RESET);
        i_host.rd(DEAD_BATT_CURRENT_OFFSET);
        exp_q.push_back(RECHARGE_REG_VOLT_RESET);
        i_host.rd(RECHARGE_REG_VOLT_OFFSET);
        $display("reset test done");
        // Saturation edge codes first, then random ones
        for (int i = 0; i < 8; i++) begin
            v = (i < 3) ? EDGE_CODES[i] : 8'($urandom);
            i_host.wr(RECHARGE_REG_VOLT_OFFSET, v);
            @(negedge sys_clk);
            `CHK(vbat_reg_mv, vmv(v[5:0]))
            `CHK(recharge_drop_mv, v[6] ? RECHARGE_HIGH_DROP_MV : RECHARGE_LOW_DROP_MV)
            exp_q.push_back(v);
            i_host.rd(RECHARGE_REG_VOLT_OFFSET);
            // Dead code kept at or below precharge, spare bits random
            precharge_current_code = 6'($urandom);
            d = 8'($urandom % (precharge_current_code + 1)) | {2'($urandom), 6'h00};
            i_host.wr(DEAD_BATT_CURRENT_OFFSET, d);
            `CHK(reg_wr_refused, 1'b0)
            @(negedge sys_clk);
            `CHK(dead_batt_current_code, d[5:0])
            `CHK(dead_batt_ma, d[5:0])
            `CHK(dead_above_precharge, 1'b0)
            exp_q.push_back(d);
            i_host.rd(DEAD_BATT_CURRENT_OFFSET);
        end
        // Advice broken: flagged, yet the code is still honoured
        precharge_current_code = 6'h00;
        i_host.wr(DEAD_BATT_CURRENT_OFFSET, 8'h3f);
        @(negedge sys_clk);
        `CHK(dead_above_precharge, 1'b1)
        `CHK(dead_batt_ma, 6'h3f)
        $display("write test done");
        charger_write_lock = 1'b1;
        i_host.wr(RECHARGE_REG_VOLT_OFFSET, ~v);
        `CHK(reg_wr_refused, 1'b1)
        exp_q.push_back(v);
        i_host.rd(RECHARGE_REG_VOLT_OFFSET);
        i_host.wr(DEAD_BATT_CURRENT_OFFSET, 8'h00);
        `CHK(reg_wr_refused, 1'b1)
        exp_q.push_back(8'h3f);
        i_host.rd(DEAD_BATT_CURRENT_OFFSET);
        exp_q.push_back(UNMAPPED_READ_VALUE);
        i_host.rd(8'h20);
        charger_write_lock = 1'b0;
        @(negedge sys_clk);
        $display("lock test done");
        // Mid-run reset must bring the reset codes back
        rst_b = 1'b0;
        @(negedge sys_clk);
        rst_b = 1'b1;
        `CHK(dead_batt_current_code, DEAD_BATT_CURRENT_RESET[5:0])
        `CHK(vbat_reg_code, RECHARGE_REG_VOLT_RESET[5:0])
        `CHK(recharge_threshold_sel, 1'b0)
        `CHK(exp_q.size(), 0)
        $display("reset rerun test done");
        end_sim();
    end
endmodule // tb
`default_nettype wire
